// >>> core/apm_map.svh
// Register offsets, field positions and reset values of the pin routing block
`ifndef APM_MAP_SVH
`define APM_MAP_SVH
`define APM_OFS_COMM      12'h004
`define APM_OFS_TIMA      12'h008
`define APM_OFS_TIMB      12'h00c
`define APM_IDX_COMM      8'h01
`define APM_IDX_TIMA      8'h02
`define APM_IDX_TIMB      8'h03
`define APM_RST_VAL       8'h00
`define APM_COMM_MASK     8'h15
`define APM_TIMA_MASK     8'h3f
`define APM_TIMB_MASK     8'h01
`define APM_BIT_TWI       4
`define APM_BIT_SPI       2
`define APM_BIT_USART     0
`define APM_BIT_TIMB      0
`endif

// >>> core/apm_pkg.sv
// Types shared by the pin routing block
`default_nettype none
package apm_pkg;
	// Routing selections driven to the peripheral pin logic
	typedef struct packed {
		logic       two_wire_pins_alt;       // Two-wire on alternative pins
		logic       serial_periph_pins_alt;  // SPI on alternative pins
		logic       async_serial_pins_alt;   // USART on alternative pins
		logic [5:0] timer_a_wave_alt;        // Timer A wave 5..0 alternative
		logic       timer_b_out_alt;         // Timer B output alternative
	} apm_route_s;
	// Access decode of an APB request
	typedef enum logic [1:0] {
		APM_SEL_NONE = 2'b00,
		APM_SEL_COMM = 2'b01,
		APM_SEL_TIMA = 2'b11,
		APM_SEL_TIMB = 2'b10
	} apm_sel_e;
endpackage : apm_pkg
`default_nettype wire

// >>> core/apm_route.sv
// APB-programmed pin routing selector for serial and timer peripherals
//
// Functional notes
// - Comm bit 4 puts two-wire on alternative pins
// - Comm bit 2 puts SPI on alternative pins
// - Comm bit 0 puts USART on alternative pins
// - Timer A bit 5 moves wave 5, split
// - Timer A bit 4 moves wave 4, split
// - Timer A bit 3 moves wave 3, split
// - Bits 5..3 ignored in normal timer mode
// - Bit 2 moves wave 2 or low compare 2
// - Bit 1 moves wave 1 or low compare 1
// - Bit 0 moves wave 0 or low compare 0
// - Timer B bit 0 moves its output
// - All routing registers reset to zero
`include "apm_map.svh"
`default_nettype none
module apm_route (
	input  wire logic           pclk,         // Peripheral clock, 10 MHz
	input  wire logic           presetn,      // Asynchronous reset, active low
	input  wire logic           clk_en,       // Freezes all state while low
	input  wire logic           psel,         // APB select
	input  wire logic           penable,      // APB access phase
	input  wire logic           pwrite,       // APB direction
	input  wire logic [11:0]    paddr,        // APB byte address
	input  wire logic [31:0]    pwdata,       // APB write data
	input  wire logic           timer_a_split,// Timer A split mode, same clock
	output logic      [31:0]    prdata,       // APB read data
	output logic                pready,       // APB ready
	output logic                pslverr,      // APB error on unmapped address
	output apm_pkg::apm_route_s route         // Routing selections
);
	import apm_pkg::*;

	logic [7:0] comm_pin_route_reg;          // Comm routing
	logic [7:0] timer_a_wave_pin_route_reg;  // Timer A routing
	logic [7:0] timer_b_pin_route_reg;       // Timer B routing
	logic [31:0] prdata_reg;                 // Registered read data
	logic        pslverr_reg;                // Registered error
	apm_sel_e    sel;                        // Decoded register
	logic        acc;                        // Access phase, taken this edge
	logic        wr;                         // Write strobe
	logic [7:0]  rd_val;                     // Selected read value
	logic [5:0]  wave_alt;                   // Timer A selections after mode gate

	// Each register keeps one byte in the low lane of an aligned word.
	// Byte lanes above bit 7 are dropped on write and read back as zero,
	// so software may write whole words without care for the upper bits.
	// Offset zero belongs to a register kept outside this block, so any
	// access there answers with an error and leaves the three routing bytes untouched.

	// Address decode; only whole aligned words are mapped
	always_comb
	begin
		case (paddr)
			`APM_OFS_COMM: sel = APM_SEL_COMM;
			`APM_OFS_TIMA: sel = APM_SEL_TIMA;
			`APM_OFS_TIMB: sel = APM_SEL_TIMB;
			default:       sel = APM_SEL_NONE;
		endcase
	end

	// Zero-wait answer, but a frozen clock holds the access open
	assign pready = clk_en;
	assign acc    = psel & penable & clk_en;
	assign wr     = acc & pwrite & (sel != APM_SEL_NONE);

	// Comm routing register; only defined bits store
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			comm_pin_route_reg <= `APM_RST_VAL;
		else if (wr && sel == APM_SEL_COMM)
			comm_pin_route_reg <= pwdata[7:0] & `APM_COMM_MASK;
	end

	// Timer A routing register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			timer_a_wave_pin_route_reg <= `APM_RST_VAL;
		else if (wr && sel == APM_SEL_TIMA)
			timer_a_wave_pin_route_reg <= pwdata[7:0] & `APM_TIMA_MASK;
	end

	// Timer B routing register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			timer_b_pin_route_reg <= `APM_RST_VAL;
		else if (wr && sel == APM_SEL_TIMB)
			timer_b_pin_route_reg <= pwdata[7:0] & `APM_TIMB_MASK;
	end

	// Read mux; reserved bits are already zero in storage
	always_comb
	begin
		case (sel)
			APM_SEL_COMM: rd_val = comm_pin_route_reg;
			APM_SEL_TIMA: rd_val = timer_a_wave_pin_route_reg;
			APM_SEL_TIMB: rd_val = timer_b_pin_route_reg;
			default:      rd_val = 8'h00;
		endcase
	end

	// Read data and error registered at setup so they are valid in access
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata_reg  <= 32'h0000_0000;
			pslverr_reg <= 1'b0;
		end
		else if (clk_en && psel && !penable)
		begin
			prdata_reg  <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_val};
			pslverr_reg <= (sel == APM_SEL_NONE);
		end
	end
	assign prdata  = prdata_reg;
	assign pslverr = pslverr_reg & psel & penable;

	// Outputs straight from flip-flops, except Timer A waves 5..3, which are ANDed with the split mode input
	always_comb
	begin
		route.two_wire_pins_alt      = comm_pin_route_reg[`APM_BIT_TWI];
		route.serial_periph_pins_alt = comm_pin_route_reg[`APM_BIT_SPI];
		route.async_serial_pins_alt  = comm_pin_route_reg[`APM_BIT_USART];
		route.timer_b_out_alt        = timer_b_pin_route_reg[`APM_BIT_TIMB];
		route.timer_a_wave_alt       = wave_alt;
	end

	// Split-only outputs gated by mode; low channels always follow
	genvar gi;
	generate
		for (gi = 0; gi < 6; gi++)
		begin : g_wave
			if (gi >= 3)
			begin : g_split
				// Upper waves exist only in split mode
				assign wave_alt[gi] =
					timer_a_wave_pin_route_reg[gi] & timer_a_split;
			end
			else
			begin : g_low
				// Wave n, or low compare n in split mode, same bit
				assign wave_alt[gi] =
					timer_a_wave_pin_route_reg[gi];
			end
		end
	endgenerate

	// Assertions
	// They watch the register bus, the stored bytes and the routing levels.
	// Writes are checked one edge after the access edge, where the stored
	// byte first shows. Holds are checked on every edge without a write,
	// so a stray update from a decode slip is caught at once.
	// The mode gate of the upper waves is combinational, so the checks on
	// it are same-cycle and follow the mode input without delay.
	// Freeze checks cover the enable, which no rule names; they check that it
	// stops the comm and Timer A bytes, the read capture included.
	chk_comm_twi: assert property (@(posedge pclk) disable iff (!presetn)
		(wr && sel == APM_SEL_COMM) |=> route.two_wire_pins_alt == $past(pwdata[4]))
		else $error("two-wire routing not updated by write");
	chk_comm_spi: assert property (@(posedge pclk) disable iff (!presetn)
		(wr && sel == APM_SEL_COMM) |=> route.serial_periph_pins_alt == $past(pwdata[2]))
		else $error("SPI routing not updated by write");
	chk_comm_usart: assert property (@(posedge pclk) disable iff (!presetn)
		(wr && sel == APM_SEL_COMM) |=> route.async_serial_pins_alt == $past(pwdata[0]))
		else $error("USART routing not updated by write");
	chk_split_upper: assert property (@(posedge pclk) disable iff (!presetn)
		timer_a_split |-> route.timer_a_wave_alt[5:3] == timer_a_wave_pin_route_reg[5:3])
		else $error("split wave routing wrong");
	chk_normal_upper: assert property (@(posedge pclk) disable iff (!presetn)
		!timer_a_split |-> route.timer_a_wave_alt[5:3] == 3'b000)
		else $error("upper waves routed in normal mode");
	chk_low_waves: assert property (@(posedge pclk) disable iff (!presetn)
		(wr && sel == APM_SEL_TIMA) |=> route.timer_a_wave_alt[2:0] == $past(pwdata[2:0]))
		else $error("low wave routing not updated");
	chk_timer_b: assert property (@(posedge pclk) disable iff (!presetn)
		(wr && sel == APM_SEL_TIMB) |=> route.timer_b_out_alt == $past(pwdata[0]))
		else $error("timer B routing not updated");
	chk_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
		(comm_pin_route_reg & ~`APM_COMM_MASK) == 8'h00
		&& (timer_a_wave_pin_route_reg & ~`APM_TIMA_MASK) == 8'h00
		&& (timer_b_pin_route_reg & ~`APM_TIMB_MASK) == 8'h00)
		else $error("reserved bit set");
	chk_reset_zero: assert property (@(posedge pclk)
		$rose(presetn) |-> comm_pin_route_reg == 8'h00 && timer_b_pin_route_reg == 8'h00)
		else $error("routing not zero after reset");
	chk_hold_idle: assert property (@(posedge pclk) disable iff (!presetn)
		!wr |=> $stable(comm_pin_route_reg) && $stable(timer_a_wave_pin_route_reg))
		else $error("register changed without write");

	// Ready simply mirrors the enable; no hidden wait states
	chk_ready_enable: assert property (@(posedge pclk) disable iff (!presetn)
		pready == clk_en)
		else $error("ready does not follow enable");

	// Frozen enable must hold the comm byte
	chk_freeze_comm: assert property (@(posedge pclk) disable iff (!presetn)
		!clk_en |=> $stable(comm_pin_route_reg))
		else $error("comm routing moved while frozen");

	// Frozen enable must hold the Timer A byte and the read capture
	chk_freeze_tim: assert property (@(posedge pclk) disable iff (!presetn)
		!clk_en |=> $stable(timer_a_wave_pin_route_reg) && $stable(prdata))
		else $error("timer routing moved while frozen");

	// Two-wire level only moves on a comm write
	chk_twi_hold: assert property (@(posedge pclk) disable iff (!presetn)
		!(wr && sel == APM_SEL_COMM) |=> $stable(route.two_wire_pins_alt))
		else $error("two-wire routing moved without write");

	// SPI level only moves on a comm write
	chk_spi_hold: assert property (@(posedge pclk) disable iff (!presetn)
		!(wr && sel == APM_SEL_COMM) |=> $stable(route.serial_periph_pins_alt))
		else $error("SPI routing moved without write");

	// USART level only moves on a comm write
	chk_usart_hold: assert property (@(posedge pclk) disable iff (!presetn)
		!(wr && sel == APM_SEL_COMM) |=> $stable(route.async_serial_pins_alt))
		else $error("USART routing moved without write");

	// Wave 5 follows its bit in split mode
	chk_wave5_split: assert property (@(posedge pclk) disable iff (!presetn)
		timer_a_split |-> route.timer_a_wave_alt[5] == timer_a_wave_pin_route_reg[5])
		else $error("wave 5 routing wrong in split mode");

	// Wave 4 follows its bit in split mode
	chk_wave4_split: assert property (@(posedge pclk) disable iff (!presetn)
		timer_a_split |-> route.timer_a_wave_alt[4] == timer_a_wave_pin_route_reg[4])
		else $error("wave 4 routing wrong in split mode");

	// Wave 3 follows its bit in split mode
	chk_wave3_split: assert property (@(posedge pclk) disable iff (!presetn)
		timer_a_split |-> route.timer_a_wave_alt[3] == timer_a_wave_pin_route_reg[3])
		else $error("wave 3 routing wrong in split mode");

	// Leaving split mode drops the upper waves in the same cycle
	chk_upper_mode_exit: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(timer_a_split) |-> route.timer_a_wave_alt[5:3] == 3'b000)
		else $error("upper waves kept after split mode ended");

	// Wave 2 follows its bit in either mode
	chk_wave2_bit: assert property (@(posedge pclk) disable iff (!presetn)
		route.timer_a_wave_alt[2] == timer_a_wave_pin_route_reg[2])
		else $error("wave 2 routing wrong");

	// Wave 1 follows its bit in either mode
	chk_wave1_bit: assert property (@(posedge pclk) disable iff (!presetn)
		route.timer_a_wave_alt[1] == timer_a_wave_pin_route_reg[1])
		else $error("wave 1 routing wrong");

	// Wave 0 follows its bit in either mode
	chk_wave0_bit: assert property (@(posedge pclk) disable iff (!presetn)
		route.timer_a_wave_alt[0] == timer_a_wave_pin_route_reg[0])
		else $error("wave 0 routing wrong");

	// Timer B level only moves on its own write
	chk_timb_hold: assert property (@(posedge pclk) disable iff (!presetn)
		!(wr && sel == APM_SEL_TIMB) |=> $stable(route.timer_b_out_alt))
		else $error("timer B routing moved without write");

	// Timer A byte and every level are clear leaving reset
	chk_reset_tima: assert property (@(posedge pclk)
		$rose(presetn) |-> timer_a_wave_pin_route_reg == 8'h00 && route == '0)
		else $error("timer A routing not zero after reset");

	// Comm read returns the stored byte in the access cycle
	chk_read_comm: assert property (@(posedge pclk) disable iff (!presetn)
		(clk_en && psel && !penable && !pwrite && sel == APM_SEL_COMM)
		|=> prdata == {24'h00_0000, $past(comm_pin_route_reg)})
		else $error("comm read data wrong");

	// Upper byte lanes always read as zero
	chk_read_upper_zero: assert property (@(posedge pclk) disable iff (!presetn)
		prdata[31:8] == 24'h00_0000)
		else $error("upper read lanes not zero");

	// Unmapped setup raises the error in the following access
	chk_err_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
		(clk_en && psel && !penable && sel == APM_SEL_NONE) |=> ((psel && penable) |-> pslverr))
		else $error("no error on unmapped access");

	// Mapped setup never raises the error
	chk_err_mapped: assert property (@(posedge pclk) disable iff (!presetn)
		(clk_en && psel && !penable && sel != APM_SEL_NONE) |=> !pslverr)
		else $error("error on mapped access");

	// Unmapped write leaves every byte alone
	chk_bad_write_ignored: assert property (@(posedge pclk) disable iff (!presetn)
		(acc && pwrite && sel == APM_SEL_NONE)
		|=> $stable(comm_pin_route_reg) && $stable(timer_a_wave_pin_route_reg)
		&& $stable(timer_b_pin_route_reg))
		else $error("unmapped write changed a register");

	cov_split_alt: cover property (@(posedge pclk) disable iff (!presetn)
		timer_a_split && route.timer_a_wave_alt[5]);
	cov_all_comm: cover property (@(posedge pclk) disable iff (!presetn)
		comm_pin_route_reg == `APM_COMM_MASK);
	cov_timer_b: cover property (@(posedge pclk) disable iff (!presetn)
		route.timer_b_out_alt);
	cov_bad_addr: cover property (@(posedge pclk) disable iff (!presetn)
		pslverr);
endmodule : apm_route
`default_nettype wire

// >>> testbench/apm_route_tb.sv
// Self-checking bench of the pin routing block over APB
`default_nettype none
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin bad_count++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); end end
module apm_route_tb;
	import apm_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, split_req = 0;
	logic clk_en = 1;                // Block enable, dropped once to test freeze
	logic [11:0] paddr = '0;         // Byte address
	logic [31:0] pwdata = '0, prdata, rd;
	logic        pready, pslverr, timer_a_split, err;
	apm_route_s  route;              // Routing selections seen
	int          bad_count = 0, compares = 0;
	int          i;
	logic [7:0]  cv [3] = '{8'h10, 8'h04, 8'h01};        // One comm bit each
	logic [9:0]  cr [3] = '{10'h200, 10'h100, 10'h080};   // Matching route
	apm_route dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.timer_a_split(timer_a_split), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .route(route));
	apm_timer_model tmr (.pclk(pclk), .presetn(presetn), .split_req(split_req),
		.timer_a_split(timer_a_split));
	// 10 MHz clock
	initial
	begin
		forever #50 pclk = ~pclk;
	end
	// Verdict and end of run
	task automatic test_done;
		$display("compares=%0d bad_count=%0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : test_done
	// One APB transfer; an idle edge after it keeps drivers single per step
	task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50)
		begin
			bad_count++;
			test_done();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : xfer
	// Mode change passes the model's register, so let two edges go by
	task automatic mode(input logic s);
		split_req <= s;
		repeat (2) @(posedge pclk);
	endtask : mode
	// Main sequence
	initial
	begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (i = 1; i < 4; i++)
		begin
			xfer(1'b0, 12'(i * 4), '0);
			`CHK(rd, 32'h0)
		end
		`CHK(route, 10'h000)
		for (i = 0; i < 3; i++)
		begin
			xfer(1'b1, 12'h004, {24'h0, cv[i]});
			`CHK(route, cr[i])
		end
		xfer(1'b1, 12'h004, 32'hffff_ffff);
		xfer(1'b0, 12'h004, '0);
		`CHK(rd, 32'h15)
		xfer(1'b1, 12'h004, 32'h0);
		xfer(1'b1, 12'h008, 32'hff);
		xfer(1'b0, 12'h008, '0);
		`CHK(rd, 32'h3f)
		`CHK(route, 10'h00e)
		mode(1'b1);
		`CHK(route, 10'h07e)
		xfer(1'b1, 12'h008, 32'h28);
		`CHK(route, 10'h050)
		mode(1'b0);
		`CHK(route, 10'h000)
		xfer(1'b1, 12'h00c, 32'hff);
		xfer(1'b0, 12'h00c, '0);
		`CHK(rd, 32'h01)
		`CHK(route, 10'h001)
		clk_en <= 1'b0;
		repeat (2) @(posedge pclk);
		`CHK(pready, 1'b0)
		`CHK(route, 10'h001)
		clk_en <= 1'b1;
		@(posedge pclk);
		xfer(1'b1, 12'h000, 32'hff);
		`CHK(err, 1'b1)
		xfer(1'b0, 12'h000, '0);
		`CHK({err, rd}, 33'h1_0000_0000)
		`CHK(route, 10'h001)
		test_done();
	end
	// Hang guard
	initial
	begin
		repeat (5000) @(posedge pclk);
		bad_count++;
		test_done();
	end
endmodule : apm_route_tb
`default_nettype wire

// >>> testbench/apm_timer_model.sv
// Timer A stand-in that reports its split mode to the routing block
`default_nettype none
module apm_timer_model (
	input  wire logic pclk,          // Peripheral clock
	input  wire logic presetn,       // Reset, active low
	input  wire logic split_req,     // Bench asks for split mode
	output logic      timer_a_split  // Mode as the timer shows it
);
	timeunit 1ns;
	timeprecision 1ns;
	// Registered like a real control bit, so a mode change lands one edge late
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			timer_a_split <= 1'b0;
		else
			timer_a_split <= split_req;
	end
endmodule : apm_timer_model
`default_nettype wire
